// ===== design/vfam_pkg.sv
package vfam_pkg;
    typedef enum logic [1:0] {VFAM_SRC_RAM, VFAM_SRC_ROM, VFAM_SRC_IO} vfam_src_t;
    typedef enum logic [2:0]
    {
        VFAM_SET_UPPER,
        VFAM_SET_GRAPH,
        VFAM_SET_REV_UPPER,
        VFAM_SET_REV_GRAPH,
        VFAM_SET_LOWER,
        VFAM_SET_UPPER_GRAPH,
        VFAM_SET_REV_LOWER,
        VFAM_SET_REV_UPPER_GRAPH
    } vfam_set_t;
endpackage : vfam_pkg

// ===== design/vfam_reg8.sv
`timescale 1ns/1ns
module vfam_reg8 #(
    parameter logic [15:0] ADDR = 16'h0000,
    parameter logic [7:0] RST = 8'h00
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    // cpu write
    input wire logic wr,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    // value
    output logic [7:0] q
);
    logic [7:0] r_q;
    wire hit = wr && (addr == ADDR);
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            r_q <= RST;
        else if (ce && hit)
            r_q <= wdata;
    end
    assign q = r_q;
endmodule : vfam_reg8

// ===== design/vfam_regs.svh
`ifndef VFAM_REGS_SVH
`define VFAM_REGS_SVH
`define VFAM_PORT_OFF 16'h0001
`define VFAM_VPTR_OFF 16'hd018
`define VFAM_BANKSEL_OFF 16'hdd00
`define VFAM_PORT_RST 8'h00
`define VFAM_VPTR_RST 8'h14
`define VFAM_BANKSEL_RST 8'h00
`define VFAM_HIDE_BIT 2
`define VFAM_CHR_LO 3'h1
`define VFAM_CHR_HI 3'h3
`define VFAM_BMP_BIT 3
`define VFAM_CROM_LO 16'hd000
`define VFAM_CROM_HI 16'hdfff
`define VFAM_IMG_LO 16'h1000
`define VFAM_IMG_HI 16'h1fff
`define VFAM_BMP_BYTES 13'd8000
`define VFAM_CROM_SEL_BIT 0
`endif

// ===== design/vfam_top.sv
`timescale 1ns/1ns
`include "vfam_regs.svh"
// Overview of operation
// - native mode: hide bit 0 shows char rom in selected bank, 1 hides it
// - native mode: rom availability applies to all four video banks
// - cpu char-rom config decodes 53248..57343 to rom instead of io
// - rom holds eight 512-byte sets in fixed order
// - character base from pointer bits 3..1, 2048-byte steps in bank
// - pointer upper nibble screen base, lower nibble char base, independent
// - bitmap mode: only bit 3 matters, offset 0 or 8192
// - bitmap spans 8000 consecutive bytes from its start
// - bank times 16K added to every char, bitmap and screen offset
// - compatibility mode: rom image only 4096..8191 bank 0, 36864..40959 bank 2
// - overlay affects video fetches only; cpu writes reach ram
// - bank from bits 1..0 of bank select register, default bank 0
module vfam_top
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    // mode
    input wire logic compat_mode,
    // cpu bus
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic cpu_ram_we,
    output vfam_pkg::vfam_src_t cpu_src,
    // video controller fetch
    input wire logic vf_req,
    input wire logic vf_bitmap,
    input wire logic vf_screen,
    input wire logic [9:0] vf_cell,
    input wire logic [7:0] vf_code,
    input wire logic [2:0] vf_row,
    input wire logic [12:0] vf_bm_idx,
    output logic vf_valid,
    output logic [15:0] vf_addr,
    output logic vf_rom,
    output logic [11:0] vf_rom_addr,
    output vfam_pkg::vfam_set_t vf_set
);
    import vfam_pkg::*;

    logic [7:0] port_q;
    logic [7:0] vptr_q;
    logic [7:0] bank_reg_q;

    vfam_reg8 #(.ADDR(`VFAM_PORT_OFF), .RST(`VFAM_PORT_RST)) u_port
    (
        .clk_sys(clk_sys), .srst(srst), .ce(ce), .wr(cpu_wr),
        .addr(cpu_addr), .wdata(cpu_wdata), .q(port_q)
    );
    vfam_reg8 #(.ADDR(`VFAM_VPTR_OFF), .RST(`VFAM_VPTR_RST)) u_vptr
    (
        .clk_sys(clk_sys), .srst(srst), .ce(ce), .wr(cpu_wr),
        .addr(cpu_addr), .wdata(cpu_wdata), .q(vptr_q)
    );
    vfam_reg8 #(.ADDR(`VFAM_BANKSEL_OFF), .RST(`VFAM_BANKSEL_RST)) u_bank
    (
        .clk_sys(clk_sys), .srst(srst), .ce(ce), .wr(cpu_wr),
        .addr(cpu_addr), .wdata(cpu_wdata), .q(bank_reg_q)
    );

    // register and cpu decode
    wire [1:0] bank = bank_reg_q[1:0];
    wire hide_rom = port_q[`VFAM_HIDE_BIT];
    wire cpu_crom_cfg = port_q[`VFAM_CROM_SEL_BIT];
    wire [3:0] scr_base = vptr_q[7:4];
    wire [2:0] chr_base = vptr_q[`VFAM_CHR_HI:`VFAM_CHR_LO];
    wire bmp_hi = vptr_q[`VFAM_BMP_BIT];
    wire in_crom = (cpu_addr >= `VFAM_CROM_LO) && (cpu_addr <= `VFAM_CROM_HI);
    wire hit_port = cpu_addr == `VFAM_PORT_OFF;
    wire hit_vptr = cpu_addr == `VFAM_VPTR_OFF;
    wire hit_bank = cpu_addr == `VFAM_BANKSEL_OFF;
    wire [7:0] rd_mux = hit_port ? port_q : hit_vptr ? vptr_q : hit_bank ? bank_reg_q : 8'h00;
    wire rom_rd = in_crom && cpu_crom_cfg;
    vfam_src_t src_d;
    assign src_d = rom_rd ? VFAM_SRC_ROM : (in_crom ? VFAM_SRC_IO : VFAM_SRC_RAM);

    // fetch offset inside 16K bank
    wire [13:0] off_chr = {chr_base, vf_code, vf_row};
    wire [13:0] off_bmp = {bmp_hi, vf_bm_idx};
    wire [13:0] off_scr = {scr_base, vf_cell};
    wire [13:0] off = vf_screen ? off_scr : (vf_bitmap ? off_bmp : off_chr);
    wire [15:0] addr_d = {bank, off};
    wire bm_in_range = !vf_bitmap || vf_screen || (vf_bm_idx < `VFAM_BMP_BYTES);
    // overlay window: the 4K image range within bank
    wire in_img = ({2'b00, off} >= `VFAM_IMG_LO) && ({2'b00, off} <= `VFAM_IMG_HI);
    wire native_rom = !compat_mode && !hide_rom && in_img;
    wire compat_rom = compat_mode && in_img && !bank[0];
    wire rom_d = vf_req && bm_in_range && (native_rom || compat_rom);

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            cpu_rdata <= 8'h00;
            cpu_ram_we <= 1'b0;
            cpu_src <= VFAM_SRC_RAM;
        end
        else if (ce)
        begin
            cpu_rdata <= cpu_rd ? rd_mux : 8'h00;
            cpu_ram_we <= cpu_wr && !(hit_port || hit_vptr || hit_bank);
            cpu_src <= src_d;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            vf_valid <= 1'b0;
            vf_addr <= 16'h0000;
            vf_rom <= 1'b0;
            vf_rom_addr <= 12'h000;
            vf_set <= VFAM_SET_UPPER;
        end
        else if (ce)
        begin
            vf_valid <= vf_req && bm_in_range;
            vf_addr <= addr_d;
            vf_rom <= rom_d;
            vf_rom_addr <= off[11:0];
            vf_set <= vfam_set_t'(off[11:9]);
        end
    end

    chk_rom_bank_any: assert property (@(posedge clk_sys) disable iff (srst)
        ce && vf_req && !vf_screen && !vf_bitmap && !compat_mode && !hide_rom && in_img
        |=> vf_rom)
        else $error("native rom missing");
    chk_rom_hidden: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !compat_mode && hide_rom |=> !vf_rom)
        else $error("rom visible while hidden");
    chk_compat_odd: assert property (@(posedge clk_sys) disable iff (srst)
        ce && compat_mode && bank[0] |=> !vf_rom)
        else $error("rom image in odd bank");
    chk_bank_high: assert property (@(posedge clk_sys) disable iff (srst)
        ce && vf_req |=> vf_addr[15:14] == $past(bank_reg_q[1:0]))
        else $error("bank bits wrong");
    chk_bitmap_base: assert property (@(posedge clk_sys) disable iff (srst)
        ce && vf_req && vf_bitmap && !vf_screen |=> vf_addr[13] == $past(vptr_q[3]))
        else $error("bitmap base wrong");
    chk_char_base: assert property (@(posedge clk_sys) disable iff (srst)
        ce && vf_req && !vf_bitmap && !vf_screen |=> vf_addr[13:11] == $past(vptr_q[3:1]))
        else $error("char base wrong");
    chk_bmp_limit: assert property (@(posedge clk_sys) disable iff (srst)
        ce && vf_req && vf_bitmap && !vf_screen && vf_bm_idx >= `VFAM_BMP_BYTES |=> !vf_valid)
        else $error("bitmap beyond 8000");
    chk_cpu_rom: assert property (@(posedge clk_sys) disable iff (srst)
        ce && in_crom && port_q[0] |=> cpu_src == VFAM_SRC_ROM)
        else $error("cpu rom decode");
    chk_ram_write: assert property (@(posedge clk_sys) disable iff (srst)
        ce && cpu_wr && !hit_port && !hit_vptr && !hit_bank |=> cpu_ram_we)
        else $error("write lost under overlay");
    chk_reg_no_ram: assert property (@(posedge clk_sys) disable iff (srst)
        ce && cpu_wr && (hit_port || hit_vptr || hit_bank) |=> !cpu_ram_we)
        else $error("register write reached ram");
    chk_cpu_io: assert property (@(posedge clk_sys) disable iff (srst)
        ce && in_crom && !port_q[`VFAM_CROM_SEL_BIT] |=> cpu_src == VFAM_SRC_IO)
        else $error("cpu io decode");
    chk_compat_even: assert property (@(posedge clk_sys) disable iff (srst)
        ce && vf_req && !vf_screen && !vf_bitmap && compat_mode && !bank[0] && in_img
        |=> vf_rom)
        else $error("rom image missing in even bank");
    chk_rom_window: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !in_img |=> !vf_rom)
        else $error("rom outside image window");
    chk_rom_addr: assert property (@(posedge clk_sys) disable iff (srst)
        ce && vf_req && !vf_screen && !vf_bitmap
        |=> vf_rom_addr == {$past(vptr_q[1]), $past(vf_code), $past(vf_row)})
        else $error("rom address wrong");
    chk_set_order: assert property (@(posedge clk_sys) disable iff (srst)
        ce |=> vf_set == vfam_set_t'(vf_rom_addr[11:9]))
        else $error("character set region wrong");
    chk_screen_base: assert property (@(posedge clk_sys) disable iff (srst)
        ce && vf_req && vf_screen |=> vf_addr[13:0] == {$past(vptr_q[7:4]), $past(vf_cell)})
        else $error("screen base wrong");
    chk_char_low: assert property (@(posedge clk_sys) disable iff (srst)
        ce && vf_req && !vf_bitmap && !vf_screen
        |=> vf_addr[10:0] == {$past(vf_code), $past(vf_row)})
        else $error("char code or row misplaced");
    chk_bmp_valid: assert property (@(posedge clk_sys) disable iff (srst)
        ce && vf_req && vf_bitmap && !vf_screen && vf_bm_idx < `VFAM_BMP_BYTES
        |=> vf_valid && vf_addr[12:0] == $past(vf_bm_idx))
        else $error("bitmap byte lost");
    chk_valid_char: assert property (@(posedge clk_sys) disable iff (srst)
        ce && vf_req && !vf_bitmap |=> vf_valid)
        else $error("fetch not served");
    chk_bank_default: assert property (@(posedge clk_sys)
        srst |=> bank_reg_q == `VFAM_BANKSEL_RST)
        else $error("bank not default after reset");
    chk_bank_read: assert property (@(posedge clk_sys) disable iff (srst)
        ce && cpu_rd && hit_bank |=> cpu_rdata == $past(bank_reg_q))
        else $error("bank register read wrong");
    chk_vptr_write: assert property (@(posedge clk_sys) disable iff (srst)
        ce && cpu_wr && hit_vptr |=> vptr_q == $past(cpu_wdata))
        else $error("pointer write lost");
    chk_hide_write: assert property (@(posedge clk_sys) disable iff (srst)
        ce && cpu_wr && hit_port |=> hide_rom == $past(cpu_wdata[`VFAM_HIDE_BIT]))
        else $error("hide bit write lost");
    chk_ce_freeze: assert property (@(posedge clk_sys) disable iff (srst)
        !ce |=> $stable(vf_addr) && $stable(vf_valid) && $stable(vf_rom) && $stable(cpu_rdata))
        else $error("state moved with enable low");
    cov_native_rom: cover property (@(posedge clk_sys) ce && !compat_mode ##1 vf_rom);
    cov_compat_rom: cover property (@(posedge clk_sys) ce && compat_mode ##1 vf_rom);
    cov_bitmap_hi: cover property (@(posedge clk_sys) vf_bitmap && bmp_hi && vf_req);
    cov_compat_bank2: cover property (@(posedge clk_sys) compat_mode && bank == 2'd2 ##1 vf_rom);
    cov_ce_hold: cover property (@(posedge clk_sys) !ce ##1 ce);
endmodule : vfam_top

// ===== tb/vfam_fetch_model.sv
`timescale 1ns/1ns
module vfam_fetch_model
(
    // clock
    input wire logic clk_sys,
    // fetch request
    output logic vf_req,
    output logic vf_bitmap,
    output logic vf_screen,
    output logic [9:0] vf_cell,
    output logic [7:0] vf_code,
    output logic [2:0] vf_row,
    output logic [12:0] vf_bm_idx
);
    initial {vf_req, vf_bitmap, vf_screen, vf_cell, vf_code, vf_row, vf_bm_idx} = '0;
    // request held through the taking edge
    task fetch(input logic [1:0] k, input logic [12:0] v, input logic [2:0] r);
        {vf_req, vf_screen, vf_bitmap} = {1'b1, k};
        {vf_cell, vf_code, vf_bm_idx, vf_row} = {v[9:0], v[7:0], v, r};
        @(posedge clk_sys);
        #1;
    endtask : fetch
    // released cell, code and bitmap index fields carry no stale value; row, bitmap and screen keep theirs
    task stop;
        vf_req = 1'b0;
        {vf_cell, vf_code, vf_bm_idx} = ~{vf_cell, vf_code, vf_bm_idx};
    endtask : stop
endmodule : vfam_fetch_model

// ===== tb/video_fetch_address_map_bench.sv
`timescale 1ns/1ns
`include "vfam_regs.svh"
module video_fetch_address_map_bench;
    import vfam_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic compat_mode = 1'b0;
    logic cpu_wr = 1'b0;
    logic cpu_rd = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0] cpu_wdata = 8'h00;
    logic [7:0] cpu_rdata, vf_code, code;
    logic cpu_ram_we, vf_req, vf_bitmap, vf_screen, vf_valid, vf_rom, p, h, e;
    logic [9:0] vf_cell;
    logic [2:0] vf_row;
    logic [12:0] vf_bm_idx;
    logic [15:0] vf_addr;
    logic [11:0] vf_rom_addr;
    logic [1:0] b;
    vfam_src_t cpu_src;
    vfam_set_t vf_set;
    int failures = 0;
    int n_tests = 0;
    always #5 clk_sys = ~clk_sys;
    vfam_top i_vfam_top (.clk_sys, .srst, .ce, .compat_mode, .cpu_wr, .cpu_rd, .cpu_addr,
        .cpu_wdata, .cpu_rdata, .cpu_ram_we, .cpu_src, .vf_req, .vf_bitmap, .vf_screen,
        .vf_cell, .vf_code, .vf_row, .vf_bm_idx, .vf_valid, .vf_addr, .vf_rom,
        .vf_rom_addr, .vf_set);
    vfam_fetch_model i_vfam_fetch_model (.clk_sys, .vf_req, .vf_bitmap, .vf_screen,
        .vf_cell, .vf_code, .vf_row, .vf_bm_idx);
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
        {cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = {w, ~w, a, d};
        @(posedge clk_sys);
        #1;
    endtask : cpu
    task fe(input logic [1:0] k, input logic [12:0] v, input logic [2:0] r,
        input logic [15:0] ea, input logic [1:0] vr);
        i_vfam_fetch_model.fetch(k, v, r);
        chk(vf_addr, ea);
        chk({14'h0000, vf_valid, vf_rom}, {14'h0000, vr});
    endtask : fe
    task end_sim;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (3) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        cpu(1'b0, `VFAM_VPTR_OFF, 8'h00);
        chk(cpu_rdata, `VFAM_VPTR_RST);
        cpu(1'b0, `VFAM_BANKSEL_OFF, 8'h00);
        chk(cpu_rdata, `VFAM_BANKSEL_RST);
        cpu(1'b1, 16'h1000, 8'h5a);
        chk(cpu_ram_we, 1'b1);
        cpu(1'b1, `VFAM_PORT_OFF, 8'h01);
        chk(cpu_ram_we, 1'b0);
        cpu(1'b0, 16'hd000, 8'h00);
        chk(cpu_src, VFAM_SRC_ROM);
        cpu(1'b1, `VFAM_PORT_OFF, 8'h00);
        cpu(1'b0, 16'hdfff, 8'h00);
        chk(cpu_src, VFAM_SRC_IO);
        cpu(1'b0, 16'h1000, 8'h00);
        chk(cpu_src, VFAM_SRC_RAM);
        $display("test cpu done");
        for (int i = 0; i < 24; i++)
        begin
            {h, p, b} = {i[3] & ~i[4], i[2], i[1:0]};
            code = {i[1:0], 6'h2a};
            e = i[4] ? ~b[0] : ~h;
            compat_mode = i[4];
            cpu(1'b1, `VFAM_BANKSEL_OFF, {6'h00, b});
            cpu(1'b1, `VFAM_PORT_OFF, {5'h00, h, 2'b00});
            cpu(1'b1, `VFAM_VPTR_OFF, {6'h05, p, 1'b0});
            fe(2'd0, {5'h00, code}, i[2:0], {b, 2'b01, p, code, i[2:0]}, {1'b1, e});
            if (e)
            begin
                chk(vf_rom_addr, {p, code, i[2:0]});
                chk(vf_set, {p, code[7:6]});
            end
        end
        compat_mode = 1'b0;
        cpu(1'b1, `VFAM_VPTR_OFF, 8'ha6);
        fe(2'd2, 13'h03ff, 3'd0, {2'd3, 4'ha, 10'h3ff}, 2'b10);
        fe(2'd0, 13'h0000, 3'd1, {2'd3, 3'b011, 8'h00, 3'd1}, 2'b11);
        fe(2'd1, 13'd0, 3'd0, 16'hc000, 2'b10);
        cpu(1'b1, `VFAM_VPTR_OFF, 8'hae);
        fe(2'd1, 13'd7999, 3'd0, {2'd3, 1'b1, 13'd7999}, 2'b10);
        ce = 1'b0;
        cpu(1'b1, `VFAM_VPTR_OFF, 8'h00);
        i_vfam_fetch_model.fetch(2'd0, 13'd0, 3'd0);
        chk(vf_addr, {2'd3, 1'b1, 13'd7999});
        ce = 1'b1;
        cpu(1'b0, `VFAM_VPTR_OFF, 8'h00);
        chk(cpu_rdata, 8'hae);
        i_vfam_fetch_model.fetch(2'd1, 13'd8000, 3'd0);
        chk({vf_valid, vf_rom}, 2'b00);
        {cpu_wr, cpu_rd} = 2'b00;
        i_vfam_fetch_model.stop();
        @(posedge clk_sys);
        $display("test fetch done");
        end_sim();
    end
    initial
    begin
        #20000;
        failures++;
        end_sim();
    end
endmodule : video_fetch_address_map_bench
